// ==== region_protection_unit.sv ====
// Region protection unit: register set and per-access check
`timescale 1ns/1ps
`default_nettype none
`include "rpu_regs.svh"
module region_protection_unit
  import rpu_pkg::*;
#(
  parameter int NREG = 8
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        reg_sel,
  input  wire logic        reg_write,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [3:0]  reg_strb,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  input  wire access_t     acc,
  output verdict_t         verdict,
  output logic             verdict_valid
);
  ////////////////////////////////////////////////////////////////////////////
  logic       rst_meta_r;
  logic       rst_sync_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  wire rst_n = rst_sync_r;

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0]  control_r;
  logic [7:0]  selector_r;
  logic [31:0] base_r [NREG];
  logic [31:0] attr_r [NREG];

  wire wr_ctl  = reg_sel && reg_write && reg_addr == `OFS_CONTROL;
  wire wr_sel  = reg_sel && reg_write && reg_addr == `OFS_SELECTOR;
  wire wr_base = reg_sel && reg_write && reg_addr == `OFS_BASE;
  wire wr_attr = reg_sel && reg_write && reg_addr == `OFS_ATTR;
  wire         base_valid = reg_wdata[`BASE_VALID_BIT];
  // A valid base write retargets before storing
  wire [7:0]   base_target = base_valid ? {4'h0, reg_wdata[`BASE_REGION_HI:0]} : selector_r;
  wire [7:0]   sel_nxt = wr_sel ? reg_wdata[`SEL_HI:0] :
                         (wr_base && base_valid) ? {4'h0, reg_wdata[`BASE_REGION_HI:0]} :
                         selector_r;
  wire [31:0]  attr_wmask = {{16{reg_strb[3] | reg_strb[2]}}, {16{reg_strb[1] | reg_strb[0]}}}
                            & `ATTR_RW_MASK;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      control_r  <= 3'h0;
      selector_r <= 8'h00;
    end else begin
      if (wr_ctl) control_r <= reg_wdata[2:0];
      selector_r <= sel_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          base_r[g] <= `RESET_WORD;
          attr_r[g] <= `RESET_WORD;
        end else begin
          if (wr_base && base_target == 8'(g))
            base_r[g] <= {reg_wdata[31:`BASE_ADDR_LO], 5'h00};
          if (wr_attr && selector_r == 8'(g))
            attr_r[g] <= (attr_r[g] & ~attr_wmask) | (reg_wdata & attr_wmask);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Region size mask: low SIZE+1 bits set, with SIZE raised to SIZE_MIN when smaller
  function automatic logic [31:0] size_mask(input logic [4:0] sz);
    logic [4:0] s;
    s = (sz < `SIZE_MIN) ? `SIZE_MIN : sz;
    return (32'h2 << s) - 32'h1;
  endfunction

  wire [2:0]  sel_idx = selector_r[2:0];
  wire [31:0] sel_mask = size_mask(attr_r[sel_idx][`ATTR_SIZE_HI:`ATTR_SIZE_LO]);
  wire [31:0] base_rd = (base_r[sel_idx] & ~sel_mask)
                        | {28'h0, selector_r[`BASE_REGION_HI:0]};
  wire [31:0] rdata_nxt =
      !reg_sel || reg_write          ? 32'h0 :
      reg_addr == `OFS_CONTROL  ? {29'h0, control_r} :
      reg_addr == `OFS_SELECTOR ? {24'h0, selector_r} :
      reg_addr == `OFS_BASE     ? base_rd :
      reg_addr == `OFS_ATTR     ? attr_r[sel_idx] : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  wire [NREG-1:0] hit;
  generate
    for (g = 0; g < NREG; g++) begin : g_match
      wire [4:0]  sz   = attr_r[g][`ATTR_SIZE_HI:`ATTR_SIZE_LO];
      wire [31:0] m    = size_mask(sz);
      wire [31:0] b    = (sz == `SIZE_FULL) ? 32'h0 : (base_r[g] & ~m);
      wire        in   = (sz == `SIZE_FULL) || ((acc.addr & ~m) == b);
      wire [31:0] off  = acc.addr & m;
      wire [4:0]  sh   = (sz < `SIZE_MIN ? `SIZE_MIN : sz) - 5'd2;
      wire [2:0]  sub  = 3'((off >> sh) & 32'h7);
      wire        soff = sz >= `SUBREG_MIN_SIZE && attr_r[g][`ATTR_SRD_LO + sub];
      assign hit[g] = attr_r[g][`ATTR_EN_BIT] && in && !soff;
    end
  endgenerate

  // Highest region wins
  logic [2:0] win;
  always_comb begin
    win = 3'h0;
    for (int i = 0; i < NREG; i++)
      if (hit[i]) win = 3'(i);
  end

  wire [31:0] wattr    = attr_r[win];
  wire        any_hit  = |hit;
  wire        in_scs   = (acc.addr & `SCS_MASK) == `SCS_BASE;
  wire        in_vtab  = acc.addr < `VTAB_LIMIT;
  wire        unit_on  = control_r[`CTL_ENABLE_BIT]
                         && (!acc.boosted || control_r[`CTL_FAULTH_BIT]);
  wire        bg_ok    = control_r[`CTL_BGMAP_BIT] && acc.priv;
  wire        always_ok = (in_scs || in_vtab) && !acc.fetch;
  wire        fault_nxt =
      (in_scs && acc.fetch) ||
      (unit_on && !always_ok &&
       (any_hit ? (acc.fetch && wattr[`ATTR_XN_BIT]) : !bg_ok));
  verdict_t v_nxt;
  always_comb begin
    v_nxt = '0;
    v_nxt.fault            = acc.valid && fault_nxt;
    v_nxt.hit              = unit_on && any_hit;
    v_nxt.background       = !(unit_on && any_hit);
    v_nxt.region           = win;
    v_nxt.perm             = (unit_on && any_hit) ? wattr[`ATTR_AP_HI:`ATTR_AP_LO] : 3'h0;
    v_nxt.mem_attr         = (unit_on && any_hit) ? wattr[`ATTR_MEM_HI:`ATTR_MEM_LO] : 6'h0;
    v_nxt.strongly_ordered = in_scs;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata     <= 32'h0;
      verdict       <= '0;
      verdict_valid <= 1'b0;
    end else begin
      reg_rdata     <= rdata_nxt;
      verdict       <= v_nxt;
      verdict_valid <= acc.valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decodes used only by the checks below
  wire rd_ctl  = reg_sel && !reg_write && reg_addr == `OFS_CONTROL;
  wire rd_sel  = reg_sel && !reg_write && reg_addr == `OFS_SELECTOR;
  wire rd_base = reg_sel && !reg_write && reg_addr == `OFS_BASE;
  wire rd_attr = reg_sel && !reg_write && reg_addr == `OFS_ATTR;

  AST_DISABLED_NO_FAULT: assert property (@(posedge clock) disable iff (!rst_n)
    (acc.valid && !control_r[`CTL_ENABLE_BIT] && !(in_scs && acc.fetch)) |=> !verdict.fault)
    else $error("fault raised while unit disabled");

  AST_SCS_FETCH: assert property (@(posedge clock) disable iff (!rst_n)
    (acc.valid && in_scs && acc.fetch) |=> verdict.fault && verdict.strongly_ordered)
    else $error("system space fetch not blocked");

  AST_UNPRIV_MISS: assert property (@(posedge clock) disable iff (!rst_n)
    (acc.valid && unit_on && !any_hit && !acc.priv && !always_ok) |=> verdict.fault)
    else $error("unprivileged miss did not fault");

  AST_PRIV_BG: assert property (@(posedge clock) disable iff (!rst_n)
    (acc.valid && unit_on && !any_hit && acc.priv && control_r[`CTL_BGMAP_BIT] && !acc.fetch)
    |=> !verdict.fault && verdict.background)
    else $error("privileged background access faulted");

  AST_NO_BG_MISS: assert property (@(posedge clock) disable iff (!rst_n)
    (acc.valid && unit_on && !any_hit && !control_r[`CTL_BGMAP_BIT] && !always_ok)
    |=> verdict.fault)
    else $error("miss without background did not fault");

  AST_BOOST_BYPASS: assert property (@(posedge clock) disable iff (!rst_n)
    (acc.valid && acc.boosted && !control_r[`CTL_FAULTH_BIT] && !in_scs) |=> !verdict.fault)
    else $error("boosted access was checked");

  AST_XN: assert property (@(posedge clock) disable iff (!rst_n)
    (acc.valid && unit_on && any_hit && acc.fetch && wattr[`ATTR_XN_BIT] && !in_vtab)
    |=> verdict.fault)
    else $error("execute-never fetch allowed");

  AST_VALID_SEL: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_base && !wr_sel && base_valid)
    |=> selector_r == {4'h0, $past(reg_wdata[`BASE_REGION_HI:0])})
    else $error("selector not retargeted");

  AST_NOVALID_SEL: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_base && !base_valid) |=> $stable(selector_r))
    else $error("selector changed on plain base write");

  AST_CTL_RB: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_ctl) ##1 rd_ctl
    |=> reg_rdata == {29'h0, $past(control_r)})
    else $error("control readback wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Register file checks
  AST_CTL_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    wr_ctl
    |=> control_r == $past(reg_wdata[`CTL_BGMAP_BIT:0]))
    else $error("control write not stored");

  AST_CTL_RSVD: assert property (@(posedge clock) disable iff (!rst_n)
    rd_ctl
    |=> (reg_rdata >> (`CTL_BGMAP_BIT + 1)) == 32'h0)
    else $error("control reserved bits not zero");

  AST_SEL_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    wr_sel
    |=> selector_r == $past(reg_wdata[`SEL_HI:0]))
    else $error("selector write not stored");

  AST_SEL_RB: assert property (@(posedge clock) disable iff (!rst_n)
    rd_sel
    |=> reg_rdata == {24'h0, $past(selector_r)})
    else $error("selector readback wrong");

  AST_BASE_RB: assert property (@(posedge clock) disable iff (!rst_n)
    rd_base
    |=> !reg_rdata[`BASE_VALID_BIT]
        && reg_rdata[`BASE_REGION_HI:0] == $past(selector_r[`BASE_REGION_HI:0]))
    else $error("base readback region field wrong");

  AST_BASE_ALIGN: assert property (@(posedge clock) disable iff (!rst_n)
    rd_base
    |=> (reg_rdata & $past(sel_mask) & ~((32'h1 << `BASE_ADDR_LO) - 32'h1)) == 32'h0)
    else $error("base bits below region size not zero");

  AST_BASE_STORE: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_base && !base_valid && selector_r < 8'(NREG))
    |=> base_r[$past(sel_idx)] == {$past(reg_wdata[31:`BASE_ADDR_LO]), 5'h00})
    else $error("plain base write missed selected region");

  AST_HALF_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_attr && !reg_strb[1] && !reg_strb[0])
    |=> attr_r[sel_idx][`ATTR_SRD_HI:0] == $past(attr_r[sel_idx][`ATTR_SRD_HI:0]))
    else $error("upper halfword write touched lower half");

  AST_ATTR_RSVD: assert property (@(posedge clock) disable iff (!rst_n)
    rd_attr
    |=> (reg_rdata & ~`ATTR_RW_MASK) == 32'h0)
    else $error("attribute reserved bits not zero");

  AST_UNMAPPED_RD: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_sel && !reg_write && reg_addr > `OFS_ATTR)
    |=> reg_rdata == 32'h0)
    else $error("unmapped offset read nonzero");

  ////////////////////////////////////////////////////////////////////////////
  // Access check properties
  AST_VTAB_DATA: assert property (@(posedge clock) disable iff (!rst_n)
    (acc.valid && unit_on && in_vtab && !acc.fetch)
    |=> !verdict.fault)
    else $error("vector table data access faulted");

  AST_SCS_DATA: assert property (@(posedge clock) disable iff (!rst_n)
    (acc.valid && in_scs && !acc.fetch)
    |=> !verdict.fault && verdict.strongly_ordered)
    else $error("system space data access faulted");

  AST_BG_RANK: assert property (@(posedge clock) disable iff (!rst_n)
    (acc.valid && unit_on && any_hit)
    |=> verdict.hit && !verdict.background)
    else $error("background outranked an enabled region");

  AST_BG_IGNORED: assert property (@(posedge clock) disable iff (!rst_n)
    (acc.valid && !control_r[`CTL_ENABLE_BIT] && !in_scs)
    |=> verdict.background && !verdict.fault)
    else $error("background bit acted with unit disabled");

  AST_DIS_NO_HIT: assert property (@(posedge clock) disable iff (!rst_n)
    (acc.valid && !control_r[`CTL_ENABLE_BIT])
    |=> !verdict.hit)
    else $error("region matched with unit disabled");

  AST_BOOST_CHECKED: assert property (@(posedge clock) disable iff (!rst_n)
    (acc.valid && acc.boosted && control_r[`CTL_ENABLE_BIT] && control_r[`CTL_FAULTH_BIT]
     && !control_r[`CTL_BGMAP_BIT] && !any_hit && !always_ok)
    |=> verdict.fault)
    else $error("protected boosted miss did not fault");

  AST_XN_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
    (acc.valid && unit_on && any_hit && acc.fetch && !wattr[`ATTR_XN_BIT] && !in_scs)
    |=> !verdict.fault)
    else $error("fetch from executable region faulted");

  AST_FULL_SPACE: assert property (@(posedge clock) disable iff (!rst_n)
    (acc.valid && unit_on && attr_r[NREG-1][`ATTR_EN_BIT]
     && attr_r[NREG-1][`ATTR_SIZE_HI:`ATTR_SIZE_LO] == `SIZE_FULL
     && attr_r[NREG-1][`ATTR_SRD_HI:`ATTR_SRD_LO] == 8'h00)
    |=> verdict.hit && verdict.region == 3'(NREG - 1))
    else $error("full space region missed an address");

  AST_TOP_REGION: assert property (@(posedge clock) disable iff (!rst_n)
    (acc.valid && hit[NREG-1])
    |=> verdict.region == 3'(NREG - 1))
    else $error("highest region did not win");

  AST_PERM_SRC: assert property (@(posedge clock) disable iff (!rst_n)
    (acc.valid && unit_on && hit[NREG-1])
    |=> verdict.perm == $past(attr_r[NREG-1][`ATTR_AP_HI:`ATTR_AP_LO]))
    else $error("permission not from winning region");

  AST_VALID_FOLLOW: assert property (@(posedge clock) disable iff (!rst_n)
    acc.valid
    |=> verdict_valid)
    else $error("verdict missing for checked access");

  AST_IDLE_QUIET: assert property (@(posedge clock) disable iff (!rst_n)
    !acc.valid
    |=> !verdict_valid && !verdict.fault)
    else $error("verdict raised without an access");

  COV_FAULT: cover property (@(posedge clock) disable iff (!rst_n) verdict.fault);
  COV_HALF:  cover property (@(posedge clock) disable iff (!rst_n) wr_attr && reg_strb == 4'hc);
  COV_HIT:   cover property (@(posedge clock) disable iff (!rst_n) verdict.hit && !verdict.fault);
  COV_BG:    cover property (@(posedge clock) disable iff (!rst_n) unit_on && bg_ok && !any_hit);
  COV_VSEL:  cover property (@(posedge clock) disable iff (!rst_n) wr_base && base_valid);
endmodule
`default_nettype wire

// ==== rpu_regs.svh ====
// Register offsets, field positions and reset values of the region protection unit
`ifndef RPU_REGS_SVH
`define RPU_REGS_SVH
`define OFS_CONTROL      8'h04
`define OFS_SELECTOR     8'h08
`define OFS_BASE         8'h0c
`define OFS_ATTR         8'h10
`define CTL_ENABLE_BIT   0
`define CTL_FAULTH_BIT   1
`define CTL_BGMAP_BIT    2
`define BASE_VALID_BIT   4
`define ATTR_XN_BIT      28
`define ATTR_EN_BIT      0
`define ATTR_SIZE_HI     5
`define ATTR_SIZE_LO     1
`define ATTR_SRD_HI      15
`define ATTR_SRD_LO      8
`define ATTR_AP_HI       26
`define ATTR_AP_LO       24
`define ATTR_MEM_HI      21
`define ATTR_MEM_LO      16
`define BASE_REGION_HI   3
`define BASE_ADDR_LO     5
`define SEL_HI           7
`define ATTR_RW_MASK     32'h173fff3f
`define SIZE_MIN         5'h04
`define SIZE_FULL        5'h1f
`define SUBREG_MIN_SIZE  5'h07
`define SCS_BASE         32'he000e000
`define SCS_MASK         32'hfffff000
`define VTAB_LIMIT       32'h00000400
`define RESET_WORD       32'h00000000
`endif

// ==== rpu_pkg.sv ====
// Types shared by the region protection unit
package rpu_pkg;
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        fetch;
    logic        priv;
    logic        boosted;
  } access_t;
  typedef struct packed {
    logic        fault;
    logic        background;
    logic        hit;
    logic [2:0]  region;
    logic [2:0]  perm;
    logic [5:0]  mem_attr;
    logic        strongly_ordered;
  } verdict_t;
endpackage

// ==== core_access_model.sv ====
// Processor core model that issues accesses to be checked
`timescale 1ns/1ps
`default_nettype none
module core_access_model
  import rpu_pkg::*;
(
  input  wire logic  clock,
  output var access_t acc
);
  initial acc = '0;
  task automatic issue(input logic [31:0] a, input logic f, input logic p, input logic b);
    @(posedge clock);
    #1;
    acc = '{valid: 1'b1, addr: a, fetch: f, priv: p, boosted: b};
    @(posedge clock);
    #1;
    // Idle bus shows a changed pattern, never the stale access
    acc = '{valid: 1'b0, addr: ~a, fetch: ~f, priv: ~p, boosted: ~b};
  endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the region protection unit
`timescale 1ns/1ps
`default_nettype none
`include "rpu_regs.svh"
module tb_top
  import rpu_pkg::*;
;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        reg_sel = 1'b0;
  logic        reg_write = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [3:0]  reg_strb = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  access_t     acc;
  verdict_t    verdict;
  logic        verdict_valid;
  int          n_mismatch = 0;
  int          checks_done = 0;
  logic [31:0] lfsr = 32'h0000002a;
  logic [31:0] rq[$];
  logic [5:0]  vq[$];
  logic [5:0]  v;
  logic        rd_was = 1'b0;

  always #2 clock = ~clock;

  region_protection_unit #(.NREG(8)) uut (.clock(clock), .rstn(rstn), .reg_sel(reg_sel),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_strb(reg_strb), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .acc(acc), .verdict(verdict), .verdict_valid(verdict_valid));
  core_access_model core (.clock(clock), .acc(acc));

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
    @(posedge clock);
    #1;
    {reg_sel, reg_write, reg_addr, reg_wdata, reg_strb} = {1'b1, w, a, d, st};
    @(posedge clock);
    #1;
    {reg_sel, reg_write} = 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st = 4'hf);
    bus(1'b1, a, d, st);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask
  // Region is compared only when er[3] is set
  task automatic chk(input logic [31:0] a, input logic f, input logic p, input logic b,
                     input logic ef, input logic [3:0] er = 4'h0);
    vq.push_back({(a & `SCS_MASK) == `SCS_BASE, er, ef});
    core.issue(a, f, p, b);
  endtask
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Sample well after the edge so registered outputs have settled
  always @(posedge clock) begin
    #2;
    if (rd_was)
      cmp("rdata", rq.pop_front(), reg_rdata);
    if (verdict_valid === 1'b1) begin
      v = vq.pop_front();
      cmp("fault", {31'h0, v[0]}, {31'h0, verdict.fault});
      cmp("strongly_ordered", {31'h0, v[5]}, {31'h0, verdict.strongly_ordered});
      // Every region this bench programs carries permission 3 and zero type bits
      if (v[4]) begin
        cmp("region", {29'h0, v[3:1]}, {29'h0, verdict.region});
        cmp("hit", 32'h1, {31'h0, verdict.hit});
        cmp("background", 32'h0, {31'h0, verdict.background});
        cmp("perm", 32'h3, {29'h0, verdict.perm});
        cmp("mem_attr", 32'h0, {26'h0, verdict.mem_attr});
      end
    end
    rd_was = (reg_sel === 1'b1) && (reg_write === 1'b0);
  end

  initial begin
    #20000;
    n_mismatch++;
    final_report;
  end

  initial begin
    repeat (3) @(posedge clock);
    #1;
    rstn = 1'b1;
    repeat (3) @(posedge clock);
    for (int k = 0; k < 5; k++)
      rd(`OFS_CONTROL + 8'(k * 4), 32'h0);
    wr(`OFS_CONTROL, 32'hffffffff);
    rd(`OFS_CONTROL, 32'h00000007);
    wr(8'h14, 32'hffffffff);
    rd(8'h14, 32'h0);
    wr(`OFS_CONTROL, 32'h0);
    wr(`OFS_SELECTOR, 32'hffffffff);
    rd(`OFS_SELECTOR, 32'h000000ff);
    wr(`OFS_BASE, 32'h200003f3);
    rd(`OFS_SELECTOR, 32'h00000003);
    wr(`OFS_ATTR, 32'hffffffff);
    rd(`OFS_ATTR, 32'h173fff3f);
    wr(`OFS_ATTR, 32'h0, 4'hc);
    rd(`OFS_ATTR, 32'h0000ff3f);
    wr(`OFS_ATTR, 32'h13000013);
    rd(`OFS_BASE, 32'h20000003);
    wr(`OFS_BASE, 32'h20000005);
    rd(`OFS_SELECTOR, 32'h00000003);
    chk(32'h30000000, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(32'he000e010, 1'b1, 1'b1, 1'b0, 1'b1);
    wr(`OFS_CONTROL, 32'h1);
    chk(32'h20000100, 1'b0, 1'b0, 1'b0, 1'b0, 4'hb);
    chk(32'h200003fc, 1'b0, 1'b0, 1'b0, 1'b0, 4'hb);
    chk(32'h20000400, 1'b0, 1'b1, 1'b0, 1'b1);
    for (int k = 0; k < 4; k++) begin
      lfsr = step(lfsr);
      chk({4'h3, lfsr[27:0]}, 1'b0, 1'b0, 1'b0, 1'b1);
    end
    chk(32'h20000100, 1'b1, 1'b1, 1'b0, 1'b1);
    chk(32'he000e010, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(32'h00000100, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(32'h30000000, 1'b0, 1'b0, 1'b1, 1'b0);
    wr(`OFS_CONTROL, 32'h3);
    chk(32'h30000000, 1'b0, 1'b0, 1'b1, 1'b1);
    wr(`OFS_CONTROL, 32'h5);
    chk(32'h30000000, 1'b0, 1'b1, 1'b0, 1'b0);
    chk(32'h30000000, 1'b0, 1'b0, 1'b0, 1'b1);
    chk(32'h20000100, 1'b0, 1'b1, 1'b0, 1'b0, 4'hb);
    wr(`OFS_CONTROL, 32'h4);
    chk(32'h30000000, 1'b0, 1'b0, 1'b0, 1'b0);
    wr(`OFS_CONTROL, 32'h1);
    wr(`OFS_ATTR, 32'h13000113);
    chk(32'h20000010, 1'b0, 1'b0, 1'b0, 1'b1);
    chk(32'h20000090, 1'b0, 1'b0, 1'b0, 1'b0, 4'hb);
    wr(`OFS_BASE, 32'h00000017);
    wr(`OFS_ATTR, 32'h0300003f);
    chk(32'h30000000, 1'b0, 1'b0, 1'b0, 1'b0, 4'hf);
    chk(32'h20000010, 1'b0, 1'b0, 1'b0, 1'b0, 4'hf);
    repeat (3) @(posedge clock);
    cmp("pending", 32'h0, 32'(vq.size() + rq.size()));
    final_report;
  end
endmodule
`default_nettype wire
